// ---- hw/hmc_halt_ctrl.sv ----
/*
  Halt mode controller: gates the cpu clock on the halt instruction and
  wakes on nmi, unmasked maskable interrupt or the reset pin.
  Assumes the cpu core and interrupt controller share i_clk, that
  i_int_req already has the mask applied, and that i_reset_n is the
  external reset pin feeding the normal reset tree.
*/
// Overview of operation
// [R1] oscillator and pll run; only cpu clock gated
// [R2] peripheral clocks keep running while halted
// [R3] halt instruction alone enters halt state
// [R4] cpu state, ram, ports frozen while halted
// [R5] halt with pending request wakes at once
// [R6] wake on nmi, unmasked interrupt or reset
// [R7] wake regardless of request priority
// [R8] lower priority in service: wake, keep pending
// [R9] higher priority or nmi: wake and accept; code resumes instead on an nmi while an nmi handler runs
// [R10] nmi branches; maskable branches only when enabled; the code does not branch on an nmi while an nmi handler runs
// [R11] reset pin wake equals ordinary reset
// [R12] memory bus, refresh, hold, clock pins keep running
`timescale 1ns/1ps
module hmc_halt_ctrl #(
  parameter int PRIO_W = hmc_pkg::HMC_PRIO_W
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_halt_exec,
  input wire logic i_nmi_req,
  input wire logic i_int_req,
  input wire logic [PRIO_W-1:0] i_int_prio,
  input wire logic i_in_service,
  input wire logic i_service_nmi,
  input wire logic [PRIO_W-1:0] i_service_prio,
  input wire logic i_interrupts_enabled_state,
  output logic o_cpu_clk_en,
  output logic o_cpu_hold,
  output logic o_halted,
  output logic o_osc_pll_run,
  output logic o_periph_clk_en,
  output logic o_mem_bus_run,
  output logic o_wake,
  output logic o_accept_nmi,
  output logic o_accept_int,
  output logic o_resume_next
);
  import hmc_pkg::*;

  // ==========================================================
  // elaboration checks
  // a zero-width priority field cannot rank requests at all
  if (PRIO_W < 1) begin : g_bad_prio_w
    $error("PRIO_W must be at least 1");
  end

  // ==========================================================
  // wake and acceptance decisions
  hmc_state_t state_ff;
  hmc_state_t nxt_state;
  logic wake_req;
  logic nmi_take;
  logic int_take;
  logic int_higher;
  logic keep_run_ff;

  // any source wakes, priority is not consulted here
  assign wake_req = i_nmi_req | i_int_req; // [R6] [R7]
  // smaller value outranks; outside a handler every request outranks
  assign int_higher = !i_in_service || (i_int_prio < i_service_prio); // [R8] [R9]
  // nmi outranks any maskable handler, but not a running nmi handler
  assign nmi_take = i_nmi_req && !(i_in_service && i_service_nmi); // [R9] [R10]
  // maskable only branches with interrupts enabled and higher priority
  assign int_take = !nmi_take && i_int_req && i_interrupts_enabled_state
    && int_higher && !i_service_nmi; // [R8] [R10]

  // ==========================================================
  // state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HMC_RUN: begin
        // entry needs nothing but the halt instruction, pending or not
        if (i_halt_exec) begin // [R3] [R5]
          nxt_state = HMC_HALT;
        end
      end
      HMC_HALT: begin
        if (wake_req) begin // [R6]
          nxt_state = HMC_RUN;
        end
      end
      default: begin
        nxt_state = HMC_RUN;
      end
    endcase
  end

  // reset pin returns to run through the ordinary reset path
  always_ff @(posedge i_clk or negedge i_reset_n) begin // [R11]
    if (!i_reset_n) begin
      state_ff <= HMC_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // clock gating and state hold, registered so outputs are glitch free
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cpu_clk_en <= HMC_RST_CPU_CLK_EN;
      o_cpu_hold <= HMC_RST_HALTED;
      o_halted <= HMC_RST_HALTED;
    end else begin
      o_cpu_clk_en <= (nxt_state != HMC_HALT); // [R1]
      o_cpu_hold <= (nxt_state == HMC_HALT); // [R4]
      o_halted <= (nxt_state == HMC_HALT);
    end
  end

  // ==========================================================
  // free-running domains; halt never touches these enables
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      keep_run_ff <= HMC_RST_KEEP_RUN;
    end else begin
      keep_run_ff <= HMC_RST_KEEP_RUN;
    end
  end
  assign o_osc_pll_run = keep_run_ff; // [R1]
  assign o_periph_clk_en = keep_run_ff; // [R2]
  assign o_mem_bus_run = keep_run_ff; // [R12]

  // ==========================================================
  // one-cycle wake outcome pulses
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wake <= HMC_RST_PULSE;
      o_accept_nmi <= HMC_RST_PULSE;
      o_accept_int <= HMC_RST_PULSE;
      o_resume_next <= HMC_RST_PULSE;
    end else if (state_ff == HMC_HALT && wake_req) begin
      o_wake <= 1'b1; // [R6] [R7]
      o_accept_nmi <= nmi_take; // [R9] [R10]
      o_accept_int <= int_take; // [R9] [R10]
      o_resume_next <= !nmi_take && !int_take; // [R8] [R10]
    end else begin
      o_wake <= 1'b0;
      o_accept_nmi <= 1'b0;
      o_accept_int <= 1'b0;
      o_resume_next <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  property p_enter;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state_ff == HMC_RUN && i_halt_exec) |=> (o_halted && !o_cpu_clk_en);
  endproperty
  a_enter: assert property (p_enter) else $error("halt not entered"); // [R3]

  property p_gate_only_cpu;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_halted |-> (!o_cpu_clk_en && o_osc_pll_run && o_periph_clk_en);
  endproperty
  a_gate_only_cpu: assert property (p_gate_only_cpu) else $error("wrong clock gated"); // [R1]

  property p_periph;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_halted) |-> o_periph_clk_en[*3];
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral clock stopped"); // [R2]

  property p_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_cpu_hold == !o_cpu_clk_en;
  endproperty
  a_hold: assert property (p_hold) else $error("cpu state not held"); // [R4]

  property p_pending;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state_ff == HMC_RUN && i_halt_exec && i_nmi_req) ##1 i_nmi_req
        |=> (o_wake && !o_halted);
  endproperty
  a_pending: assert property (p_pending) else $error("pending request lost"); // [R5]

  property p_wake;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_halted && (i_nmi_req || i_int_req)) |=> (o_wake && o_cpu_clk_en);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on request"); // [R6]

  property p_low_prio;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_halted && i_int_req && !i_nmi_req && i_in_service
        && i_int_prio >= i_service_prio) |=> (o_resume_next && !o_accept_int);
  endproperty
  a_low_prio: assert property (p_low_prio) else $error("low priority accepted"); // [R8]

  property p_nmi;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_halted && i_nmi_req && !i_service_nmi) |=> o_accept_nmi;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not accepted"); // [R9]

  property p_disabled;
    @(posedge i_clk) disable iff (!i_reset_n)
      (o_halted && i_int_req && !i_nmi_req && !i_interrupts_enabled_state)
        |=> (o_resume_next && !o_accept_int);
  endproperty
  a_disabled: assert property (p_disabled) else $error("branch while disabled"); // [R10]

  property p_one_outcome;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_wake |-> $onehot({o_accept_nmi, o_accept_int, o_resume_next}) ##1 !o_wake;
  endproperty
  a_one_outcome: assert property (p_one_outcome) else $error("bad wake outcome"); // [R10]

  property p_mem;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_halted |-> o_mem_bus_run;
  endproperty
  a_mem: assert property (p_mem) else $error("memory bus stopped"); // [R12]

  c_nmi_wake: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_halted) ##[1:20] o_accept_nmi);
  c_int_wake: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_halted) ##[1:20] o_accept_int);
  c_resume: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_halted) ##[1:20] o_resume_next);
endmodule : hmc_halt_ctrl

// ---- hw/hmc_pkg.sv ----
/*
  Shared constants and types for the halt mode controller.
  Assumes one system clock and an active-low asynchronous reset.
*/
package hmc_pkg;
  // ==========================================================
  // controller states
  typedef enum logic [1:0] {
    HMC_RUN  = 2'b00,
    HMC_HALT = 2'b01
  } hmc_state_t;

  // ==========================================================
  // reset values of the outputs
  localparam logic HMC_RST_CPU_CLK_EN = 1'b1;
  localparam logic HMC_RST_HALTED = 1'b0;
  localparam logic HMC_RST_PULSE = 1'b0;
  localparam logic HMC_RST_KEEP_RUN = 1'b1;

  // ==========================================================
  // default priority field width (smaller value is more urgent)
  localparam int HMC_PRIO_W = 3;
endpackage : hmc_pkg

// ---- verif/hmc_cpu_model.sv ----
/*
  Behavioural cpu core and interrupt controller facing the halt controller.
  Assumes the bench gives one-cycle commands just after a rising edge.
*/
`timescale 1ns/1ps
module hmc_cpu_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_halt_cmd,
  input wire logic i_nmi_cmd,
  input wire logic i_int_cmd,
  input wire logic i_clear,
  input wire logic i_accept_nmi,
  input wire logic i_accept_int,
  output logic o_halt_exec,
  output logic o_nmi_req,
  output logic o_int_req
);
  // ==========================================================
  // halt instruction is a one-cycle pulse from the decoder
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) o_halt_exec <= 1'b0;
    else o_halt_exec <= i_halt_cmd;
  end

  // requests stay pending until accepted or cleared; a resume leaves them standing
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_nmi_req <= 1'b0;
      o_int_req <= 1'b0;
    end else begin
      o_nmi_req <= !i_clear && !i_accept_nmi && (i_nmi_cmd || o_nmi_req);
      o_int_req <= !i_clear && !i_accept_int && (i_int_cmd || o_int_req);
    end
  end
endmodule : hmc_cpu_model

// ---- verif/tb_halt_mode_control.sv ----
/*
  Self-checking bench for the halt controller: corner and random wake cases.
  Assumes hmc_pkg and the partner model are compiled first.
*/
`timescale 1ns/1ps
module tb_halt_mode_control;
  import hmc_pkg::*;
  logic i_clk, i_reset_n, halt_cmd, nmi_cmd, int_cmd, clr, ins, sn, en;
  logic [HMC_PRIO_W-1:0] ip, sp;
  logic halt_exec, nmi_req, int_req, clk_en, hold, halted, osc, per, mem, wake, a_nmi, a_int, res;
  logic [31:0] seed = 32'h24A7;
  logic [31:0] r;
  int mismatches, checked;

  hmc_halt_ctrl uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_halt_exec(halt_exec),
    .i_nmi_req(nmi_req), .i_int_req(int_req), .i_int_prio(ip), .i_in_service(ins),
    .i_service_nmi(sn), .i_service_prio(sp), .i_interrupts_enabled_state(en),
    .o_cpu_clk_en(clk_en), .o_cpu_hold(hold), .o_halted(halted), .o_osc_pll_run(osc),
    .o_periph_clk_en(per), .o_mem_bus_run(mem), .o_wake(wake), .o_accept_nmi(a_nmi),
    .o_accept_int(a_int), .o_resume_next(res));
  hmc_cpu_model partner (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_halt_cmd(halt_cmd),
    .i_nmi_cmd(nmi_cmd), .i_int_cmd(int_cmd), .i_clear(clr), .i_accept_nmi(a_nmi),
    .i_accept_int(a_int), .o_halt_exec(halt_exec), .o_nmi_req(nmi_req), .o_int_req(int_req));

  // ==========================================================
  // clock and helpers
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // smaller priority value wins; equal priority is not higher, so it resumes
  function logic [2:0] exp_dec(input logic n, i, s, snm, e, input logic [HMC_PRIO_W-1:0] p, q);
    if (n && !(s && snm)) return 3'b100;
    if (i && e && (!s || p < q) && !snm) return 3'b010;
    return 3'b001;
  endfunction : exp_dec

  task finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task chk(input logic [2:0] seen, input logic [2:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %b expected %b", $time, msg, seen, exp);
    end
  endtask : chk

  task step();
    @(posedge i_clk);
    #1;
  endtask : step

  // one halt and wake; pre raises the request before the halt instruction
  task run_case(input logic n, i, s, snm, e, pre, input logic [HMC_PRIO_W-1:0] p, q);
    int k;
    ins = s; sn = snm; en = e; ip = p; sp = q;
    if (pre) begin
      nmi_cmd = n; int_cmd = i; step(); nmi_cmd = 0; int_cmd = 0;
    end
    halt_cmd = 1; step(); halt_cmd = 0; step();
    chk({halted, clk_en, hold}, 3'b101, "halt entry");
    chk({osc, per, mem}, 3'b111, "run enables while halted");
    if (!pre) begin
      nmi_cmd = n; int_cmd = i; step(); nmi_cmd = 0; int_cmd = 0;
    end
    for (k = 0; k < 8 && wake !== 1'b1; k++) step();
    if (k == 8) begin
      mismatches++;
      $display("CHECK FAILED t=%0t no wake", $time);
      finish_test();
    end
    // a request pending at entry is seen on the first halted edge, a late one on its own
    chk(k[2:0], 3'd1, "wake latency");
    chk({a_nmi, a_int, res}, exp_dec(n, i, s, snm, e, p, q), "wake decision");
    chk({halted, clk_en, hold}, 3'b010, "run after wake");
    clr = 1; step(); clr = 0; step();
    $display("case done n=%b i=%b svc=%b en=%b pre=%b", n, i, s, e, pre);
  endtask : run_case

  // ==========================================================
  // main sequence
  initial begin
    {i_reset_n, halt_cmd, nmi_cmd, int_cmd, clr, ins, sn, en, ip, sp} = '0;
    repeat (3) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    step();
    run_case(1, 0, 1, 1, 1, 0, 0, 0);
    run_case(0, 1, 1, 0, 1, 0, 3, 3);
    run_case(0, 1, 1, 0, 1, 0, 2, 3);
    run_case(0, 1, 0, 0, 0, 1, 5, 0);
    run_case(1, 1, 1, 0, 0, 1, 7, 0);
    repeat (40) begin
      r = rnd();
      run_case(r[0] | ~r[1], r[1], r[2], r[2] & r[3], r[4], r[5], r[8:6], r[11:9]);
    end
    // reset pin while halted behaves as a plain reset
    halt_cmd = 1; step(); halt_cmd = 0; step();
    i_reset_n = 1'b0;
    #5 chk({halted, clk_en, hold}, 3'b010, "reset in halt");
    chk({wake, osc, per}, 3'b011, "reset outputs");
    step();
    i_reset_n = 1'b1;
    step();
    chk({halted, clk_en, hold}, 3'b010, "run after reset");
    // a halt right after the reset must behave as after power-up
    run_case(1, 0, 0, 0, 1, 0, 4, 0);
    $display("reset case done");
    finish_test();
  end
endmodule : tb_halt_mode_control
